//--- common/gas_param_map.vh
`ifndef GAS_PARAM_MAP_VH
`define GAS_PARAM_MAP_VH

// register offsets (byte addresses)
`define GP_REG_CMD        8'h00
`define GP_REG_STATUS     8'h04
`define GP_REG_PARAM0     8'h08
`define GP_REG_PARAM_LAST 8'h20
`define GP_REG_VOC_STATE0 8'h24
`define GP_REG_VOC_STATE1 8'h28
`define GP_REG_MEAS_COUNT 8'h2c

// command register bits
`define GP_CMD_BEGIN      0
`define GP_CMD_STOP       1
`define GP_CMD_COMMIT     2
`define GP_CMD_RESET      3
`define GP_CMD_CLR_REJECT 4

// status register bits
`define GP_ST_MEASURE     0
`define GP_ST_LOADING     1
`define GP_ST_COMMITTING  2
`define GP_ST_DIRTY       3
`define GP_ST_REJECT      4
`define GP_ST_LEARNING    5
`define GP_ST_STATES_PEND 6
`define GP_ST_VOC_FREEZE  7
`define GP_ST_NOX_FREEZE  8

// parameter slots
`define GP_NUM_PARAMS     7
`define GP_IDX_TEMP       3'h0
`define GP_IDX_VOC_GATE   3'h1
`define GP_IDX_VOC_STD    3'h2
`define GP_IDX_VOC_GAIN   3'h3
`define GP_IDX_NOX_GATE   3'h4
`define GP_IDX_NOX_STD    3'h5
`define GP_IDX_NOX_GAIN   3'h6

// limits and defaults
`define GP_GATE_DEF       16'h00b4
`define GP_GATE_MIN       16'h0000
`define GP_GATE_MAX       16'h0bb8
`define GP_STD_DEF        16'h0032
`define GP_STD_MIN        16'h000a
`define GP_STD_MAX        16'h1388
`define GP_GAIN_DEF       16'h00e6
`define GP_GAIN_MIN       16'h0001
`define GP_GAIN_MAX       16'h03e8
`define GP_TEMP_DEF       16'h0000

// timing
`define GP_CLK_HZ         125000000
`define GP_SEC_CYCLES     27'd125000000
`define GP_MIN_SECONDS    6'd59
`define GP_LEARN_MIN      8'd90
`define GP_COMMIT_MS      500
`define GP_RESET_MS       100

`endif

//--- logic/gas_index_param_store_ctrl.v
// Summary of operation
// - gating duration 0..3000 minutes, default 180
// - freeze estimator while index high; 0 disables
// - initial std dev 10..5000, startup only
// - gain factor 1..1000, default 230
// - commit parameters to store within 500 ms
// - store accepted in idle and measure mode
// - after any reset, load committed parameters
// - restored states skip 90 minute learning phase
// - restored states applied at next measure start
// - state save and restore only for VOC
// - reset command replies, then restarts to idle; here a reset written while loading or before the last commit word is ignored
// - reset discards uncommitted values and states
// - temperature offset set only in idle
// - one measurement per second in measure mode
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "gas_param_map.vh"

module gas_index_param_store_ctrl #(
  parameter [26:0] SEC_CYCLES = `GP_SEC_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // non-volatile store
  output reg         nvRdEn,
  output reg         nvWrEn,
  output reg  [2:0]  nvAddr,
  output reg  [15:0] nvWdata,
  input  wire [15:0] nvRdata,
  // processing firmware
  input  wire [1:0]  indexHigh,
  input  wire [31:0] vocStateIn0,
  input  wire [31:0] vocStateIn1,
  output reg         measuring,
  output reg         measureTick,
  output reg         startupPhase,
  output wire [1:0]  estimatorFreeze,
  output reg         vocStateLoad,
  output reg  [31:0] vocStateOut0,
  output reg  [31:0] vocStateOut1,
  output wire [15:0] tempOffset,
  output wire [15:0] vocGate,
  output wire [15:0] vocStdDev,
  output wire [15:0] vocGain,
  output wire [15:0] noxGate,
  output wire [15:0] noxStdDev,
  output wire [15:0] noxGain
);
  localparam [1:0] ST_LOAD    = 2'h0;
  localparam [1:0] ST_RUN     = 2'h1;
  localparam [1:0] ST_COMMIT  = 2'h2;
  localparam [1:0] ST_RESTART = 2'h3;
  reg  [1:0]  rstPipe;
  wire        rstn = rstPipe[1];

  reg  [1:0]  state;
  reg  [2:0]  idx;
  reg         loadCapture;
  reg  [2:0]  loadIdx;
  reg  [15:0] param [0:6];
  reg         dirty;
  reg         reject;
  reg         statesPending;
  reg  [31:0] restore0;
  reg  [31:0] restore1;
  reg         skipLearn;
  reg  [26:0] secCnt;
  reg  [5:0]  secOfMin;
  reg         minuteTick;
  reg  [7:0]  learnMin;
  reg  [31:0] measCount;
  function [15:0] defVal;
    input [2:0] i;
    begin
      case (i)
        `GP_IDX_VOC_GATE, `GP_IDX_NOX_GATE: defVal = `GP_GATE_DEF;
        `GP_IDX_VOC_STD,  `GP_IDX_NOX_STD:  defVal = `GP_STD_DEF;
        `GP_IDX_VOC_GAIN, `GP_IDX_NOX_GAIN: defVal = `GP_GAIN_DEF;
        default: defVal = `GP_TEMP_DEF;
      endcase
    end
  endfunction
  function inRange;
    input [2:0]  i;
    input [15:0] v;
    begin
      case (i)
        `GP_IDX_VOC_GATE, `GP_IDX_NOX_GATE: inRange = (v <= `GP_GATE_MAX);
        `GP_IDX_VOC_STD,  `GP_IDX_NOX_STD:  inRange = (v >= `GP_STD_MIN) && (v <= `GP_STD_MAX);
        `GP_IDX_VOC_GAIN, `GP_IDX_NOX_GAIN: inRange = (v >= `GP_GAIN_MIN) && (v <= `GP_GAIN_MAX);
        default: inRange = 1'b1;
      endcase
    end
  endfunction
  assign tempOffset = param[0];
  assign vocGate    = param[1];
  assign vocStdDev  = param[2];
  assign vocGain    = param[3];
  assign noxGate    = param[4];
  assign noxStdDev  = param[5];
  assign noxGain    = param[6];
  // register decode
  wire        running   = (state == ST_RUN);
  wire        cmdWr     = wr && (addr == `GP_REG_CMD);
  wire        paramHit  = (addr >= `GP_REG_PARAM0) && (addr <= `GP_REG_PARAM_LAST)
                          && (addr[1:0] == 2'h0);
  wire [7:0]  paramOff  = addr - `GP_REG_PARAM0;
  wire [2:0]  wrIdx     = paramOff[4:2];
  wire        paramWr   = wr && paramHit;
  wire        tempBlock = (wrIdx == `GP_IDX_TEMP) && measuring;
  wire        paramOk   = paramWr && running && !tempBlock && inRange(wrIdx, wdata[15:0]);
  wire        stateWr   = wr && ((addr == `GP_REG_VOC_STATE0) || (addr == `GP_REG_VOC_STATE1));
  wire        stateOk   = stateWr && running && !measuring;
  wire        paramBad  = (paramWr || stateWr) && !paramOk && !stateOk;
  wire        beginCmd  = cmdWr && running && wdata[`GP_CMD_BEGIN] && !measuring;
  wire        stopCmd   = cmdWr && running && wdata[`GP_CMD_STOP];
  wire        commitCmd = cmdWr && running && wdata[`GP_CMD_COMMIT];
  wire        resetCmd  = cmdWr && wdata[`GP_CMD_RESET];
  wire        restart   = (state == ST_RESTART);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  // load, commit and restart sequencing
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state       <= ST_LOAD;
      idx         <= 3'h0;
      nvRdEn      <= 1'b0;
      nvWrEn      <= 1'b0;
      nvAddr      <= 3'h0;
      nvWdata     <= 16'h0000;
      loadCapture <= 1'b0;
      loadIdx     <= 3'h0;
    end else begin
      nvRdEn      <= 1'b0;
      nvWrEn      <= 1'b0;
      loadCapture <= nvRdEn;
      loadIdx     <= nvAddr;
      case (state)
        ST_LOAD: begin
          // one read per cycle, data captured the cycle after
          if (!nvRdEn && !loadCapture && idx == 3'h0) begin
            nvRdEn <= 1'b1;
            nvAddr <= 3'h0;
            idx    <= 3'h1;
          end else if (idx != 3'h0 && idx < `GP_NUM_PARAMS) begin
            nvRdEn <= 1'b1;
            nvAddr <= idx;
            idx    <= idx + 3'h1;
          end else if (idx == `GP_NUM_PARAMS && !nvRdEn && !loadCapture) begin
            idx   <= 3'h0;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (resetCmd) begin
            state <= ST_RESTART;
          end else if (commitCmd && dirty) begin
            state <= ST_COMMIT;
            idx   <= 3'h0;
          end
        end
        ST_COMMIT: begin
          // seven words, far inside the 500 ms budget
          nvWrEn  <= 1'b1;
          nvAddr  <= idx;
          nvWdata <= param[idx];
          if (idx == `GP_NUM_PARAMS - 1) begin
            idx   <= 3'h0;
            state <= resetCmd ? ST_RESTART : ST_RUN;
          end else begin
            idx <= idx + 3'h1;
          end
        end
        ST_RESTART: begin
          idx   <= 3'h0;
          state <= ST_LOAD;
        end
        default: state <= ST_LOAD;
      endcase
    end
  end

  // working parameters
  integer k;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (k = 0; k < `GP_NUM_PARAMS; k = k + 1) begin
        param[k] <= defVal(k[2:0]);
      end
    end else if (restart) begin
      for (k = 0; k < `GP_NUM_PARAMS; k = k + 1) begin
        param[k] <= defVal(k[2:0]);
      end
    end else if (loadCapture) begin
      // an out-of-range word falls back to the default; any temperature word is kept
      param[loadIdx] <= inRange(loadIdx, nvRdata) ? nvRdata : defVal(loadIdx);
    end else if (paramOk) begin
      param[wrIdx] <= wdata[15:0];
    end
  end

  // flags and restored states
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dirty         <= 1'b0;
      reject        <= 1'b0;
      statesPending <= 1'b0;
      restore0      <= 32'h00000000;
      restore1      <= 32'h00000000;
    end else if (restart) begin
      dirty         <= 1'b0;
      reject        <= 1'b0;
      statesPending <= 1'b0;
    end else begin
      if (paramOk) begin
        dirty <= 1'b1;
      end else if (state == ST_COMMIT && idx == `GP_NUM_PARAMS - 1) begin
        dirty <= 1'b0;
      end
      // a new refusal wins over a clear in the same cycle
      if (paramBad) begin
        reject <= 1'b1;
      end else if (cmdWr && wdata[`GP_CMD_CLR_REJECT]) begin
        reject <= 1'b0;
      end
      if (stateOk) begin
        statesPending <= 1'b1;
        if (addr == `GP_REG_VOC_STATE0) begin
          restore0 <= wdata;
        end else begin
          restore1 <= wdata;
        end
      end else if (beginCmd) begin
        statesPending <= 1'b0;
      end
    end
  end

  // measure mode and time base
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      measuring    <= 1'b0;
      measureTick  <= 1'b0;
      minuteTick   <= 1'b0;
      secCnt       <= 27'h0000000;
      secOfMin     <= 6'h00;
      learnMin     <= 8'h00;
      skipLearn    <= 1'b0;
      startupPhase <= 1'b0;
      vocStateLoad <= 1'b0;
      vocStateOut0 <= 32'h00000000;
      vocStateOut1 <= 32'h00000000;
      measCount    <= 32'h00000000;
    end else begin
      measureTick  <= 1'b0;
      minuteTick   <= 1'b0;
      vocStateLoad <= 1'b0;
      if (restart || stopCmd) begin
        measuring    <= 1'b0;
        startupPhase <= 1'b0;
        secCnt       <= 27'h0000000;
        secOfMin     <= 6'h00;
      end else if (beginCmd) begin
        measuring    <= 1'b1;
        secCnt       <= 27'h0000000;
        secOfMin     <= 6'h00;
        learnMin     <= 8'h00;
        skipLearn    <= statesPending;
        startupPhase <= !statesPending;
        vocStateLoad <= statesPending;
        vocStateOut0 <= restore0;
        vocStateOut1 <= restore1;
      end else if (measuring) begin
        // free-running: result reads do not touch the cadence
        if (secCnt == SEC_CYCLES - 27'h1) begin
          secCnt      <= 27'h0000000;
          measureTick <= 1'b1;
          measCount   <= measCount + 32'h1;
          if (secOfMin == `GP_MIN_SECONDS) begin
            secOfMin   <= 6'h00;
            minuteTick <= 1'b1;
          end else begin
            secOfMin <= secOfMin + 6'h01;
          end
        end else begin
          secCnt <= secCnt + 27'h1;
        end
        if (minuteTick && learnMin != `GP_LEARN_MIN) begin
          learnMin <= learnMin + 8'h01;
        end
        startupPhase <= !skipLearn && (learnMin != `GP_LEARN_MIN);
      end
    end
  end

  // gating per algorithm: VOC then NOx
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gating
      wire [15:0] limit = param[1 + 3 * g];
      reg  [11:0] highMin;
      reg         frz;
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          highMin <= 12'h000;
          frz     <= 1'b0;
        end else if (restart || !measuring || !indexHigh[g]) begin
          highMin <= 12'h000;
          frz     <= 1'b0;
        end else begin
          if (minuteTick && {4'h0, highMin} < limit) begin
            highMin <= highMin + 12'h001;
          end
          // zero limit never freezes
          frz <= (limit != `GP_GATE_MIN) && ({4'h0, highMin} < limit);
        end
      end
      assign estimatorFreeze[g] = frz;
    end
  endgenerate
  // read data, valid the cycle after the strobe
  wire [31:0] status = {23'h000000,
                        estimatorFreeze[1], estimatorFreeze[0],
                        statesPending, startupPhase, reject, dirty,
                        state == ST_COMMIT, state == ST_LOAD || restart,
                        measuring};
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      if (addr == `GP_REG_STATUS) begin
        rdata <= status;
      end else if (paramHit) begin
        rdata <= {16'h0000, param[wrIdx]};
      end else if (addr == `GP_REG_VOC_STATE0) begin
        rdata <= vocStateIn0;
      end else if (addr == `GP_REG_VOC_STATE1) begin
        rdata <= vocStateIn1;
      end else if (addr == `GP_REG_MEAS_COUNT) begin
        rdata <= measCount;
      end else begin
        rdata <= 32'h00000000;
      end
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule

//--- bench/gas_ctrl_props.sv
`timescale 1ns/1ps
`include "gas_param_map.vh"
module gas_ctrl_props #(
  parameter [26:0] SEC_CYCLES = 27'd10
) (
  // clock and reset
  input wire        clk,
  input wire        resetn,
  // register port
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  // store and firmware side
  input wire        nvRdEn,
  input wire        nvWrEn,
  input wire [2:0]  nvAddr,
  input wire [1:0]  indexHigh,
  input wire        measuring,
  input wire        measureTick,
  input wire        startupPhase,
  input wire [1:0]  estimatorFreeze,
  input wire        vocStateLoad,
  input wire [15:0] tempOffset,
  input wire [15:0] vocGate,
  input wire [15:0] vocStdDev,
  input wire [15:0] vocGain,
  input wire [15:0] noxGate
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  reg  [27:0] gap;
  reg         setSeen;
  wire        cmdReset = wr && addr == `GP_REG_CMD && wdata[`GP_CMD_RESET];
  // setSeen errs towards 1, so a missed clear can only hide a fault
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap <= 28'h0;
      setSeen <= 1'b0;
    end else begin
      gap <= (!measuring || measureTick) ? 28'h0 : gap + 28'h1;
      if (cmdReset)
        setSeen <= 1'b0;
      else if (wr && addr >= `GP_REG_PARAM0 && addr <= `GP_REG_PARAM_LAST)
        setSeen <= 1'b1;
    end
  end
  a_tick_in_measure: assert property (measureTick |-> measuring)
    else $error("tick outside measure mode");
  a_tick_spacing: assert property (measureTick |=> !measureTick [*8])
    else $error("ticks too close");
  a_tick_period: assert property (gap <= {1'b0, SEC_CYCLES} + 28'h2)
    else $error("tick missing");
  a_freeze_cause: assert property (
    estimatorFreeze[0] |-> $past(indexHigh[0]) && $past(measuring))
    else $error("freeze without high index");
  a_gate_off: assert property (
    (vocGate == 16'h0000 && $past(vocGate) == 16'h0000) |-> !estimatorFreeze[0])
    else $error("freeze with zero gate");
  a_nox_gate_off: assert property (
    (noxGate == 16'h0000 && $past(noxGate) == 16'h0000) |-> !estimatorFreeze[1])
    else $error("second freeze with zero gate");
  a_param_range: assert property (
    vocGate <= `GP_GATE_MAX && vocStdDev >= `GP_STD_MIN && vocStdDev <= `GP_STD_MAX
    && vocGain >= `GP_GAIN_MIN && vocGain <= `GP_GAIN_MAX)
    else $error("parameter out of range");
  a_restore_skip: assert property (vocStateLoad |=> !vocStateLoad && !startupPhase)
    else $error("restored states not skipping learning");
  a_store_noop: assert property (nvWrEn |-> setSeen)
    else $error("store write without prior set");
  a_temp_idle: assert property (measuring && $past(measuring) |-> $stable(tempOffset))
    else $error("offset changed while measuring");
  a_reset_idle: assert property (cmdReset |-> ##[1:3] !measuring ##[0:20] nvRdEn)
    else $error("soft reset did not restart");
  a_nv_slot: assert property ((nvWrEn || nvRdEn) |-> nvAddr <= 3'h6)
    else $error("store slot out of range");
endmodule

//--- bench/nv_store_model.sv
`timescale 1ns/1ps
`include "gas_param_map.vh"
module nv_store_model (
  // store port
  input  wire        clk,
  input  wire        nvRdEn,
  input  wire        nvWrEn,
  input  wire [2:0]  nvAddr,
  input  wire [15:0] nvWdata,
  output reg  [15:0] nvRdata
);
  reg [15:0] mem [0:6];
  initial begin
    mem[0] = `GP_TEMP_DEF;
    mem[1] = `GP_GATE_DEF;
    mem[2] = `GP_STD_DEF;
    mem[3] = `GP_GAIN_DEF;
    mem[4] = `GP_GATE_DEF;
    mem[5] = `GP_STD_DEF;
    mem[6] = `GP_GAIN_DEF;
    nvRdata = 16'h5a5a;
  end
  // contents outlive any reset; read data is stale garbage unless just asked for
  always @(posedge clk) begin
    if (nvWrEn)
      mem[nvAddr] <= nvWdata;
    nvRdata <= nvRdEn ? mem[nvAddr] : ~nvRdata;
  end
endmodule

//--- bench/gas_index_param_store_ctrl_tb.sv
`timescale 1ns/1ps
`include "gas_param_map.vh"
module gas_index_param_store_ctrl_tb;
  reg         clk;
  reg         resetn;
  reg  [7:0]  addr;
  reg  [31:0] wdata;
  reg         wr;
  reg         rd;
  reg  [1:0]  indexHigh;
  reg  [31:0] vocStateIn0;
  reg  [31:0] vocStateIn1;
  wire [31:0] rdata;
  wire        nvRdEn;
  wire        nvWrEn;
  wire [2:0]  nvAddr;
  wire [15:0] nvWdata;
  wire [15:0] nvRdata;
  wire        measuring;
  wire        measureTick;
  wire        startupPhase;
  wire [1:0]  estimatorFreeze;
  wire        vocStateLoad;
  wire [31:0] vocStateOut0;
  wire [31:0] vocStateOut1;
  wire [15:0] tempOffset;
  wire [15:0] vocGate;
  wire [15:0] vocStdDev;
  wire [15:0] vocGain;
  wire [15:0] noxGate;
  wire [15:0] noxStdDev;
  wire [15:0] noxGain;
  reg  [31:0] keptState0;
  reg  [31:0] keptState1;
  integer     err_count;
  integer     n_compared;
  integer     cycles;
  // ten cycles a second keeps minutes short
  gas_index_param_store_ctrl #(.SEC_CYCLES(27'd10)) dut (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .nvRdEn(nvRdEn), .nvWrEn(nvWrEn), .nvAddr(nvAddr), .nvWdata(nvWdata),
    .nvRdata(nvRdata), .indexHigh(indexHigh), .vocStateIn0(vocStateIn0),
    .vocStateIn1(vocStateIn1), .measuring(measuring), .measureTick(measureTick),
    .startupPhase(startupPhase), .estimatorFreeze(estimatorFreeze),
    .vocStateLoad(vocStateLoad), .vocStateOut0(vocStateOut0), .vocStateOut1(vocStateOut1),
    .tempOffset(tempOffset), .vocGate(vocGate), .vocStdDev(vocStdDev), .vocGain(vocGain),
    .noxGate(noxGate), .noxStdDev(noxStdDev), .noxGain(noxGain));
  nv_store_model nv (
    .clk(clk), .nvRdEn(nvRdEn), .nvWrEn(nvWrEn), .nvAddr(nvAddr), .nvWdata(nvWdata),
    .nvRdata(nvRdata));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wreg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [7:0] a, output [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
    end
  endtask
  task settle;
    integer    k;
    reg [31:0] s;
    begin
      // loading only shows once the reset synchroniser has let go
      repeat (3) @(posedge clk);
      s = 32'h6;
      for (k = 0; k < 60 && (s & 32'h6) != 0; k = k + 1)
        rreg(`GP_REG_STATUS, s);
      chk("busy", s & 32'h6, 32'h0);
    end
  endtask
  task count_nv(input integer len, output integer n);
    begin
      n = 0;
      repeat (len) begin
        @(posedge clk);
        #1;
        if (nvWrEn === 1'b1)
          n = n + 1;
      end
    end
  endtask
  task tryset(input [7:0] a, input [31:0] d, input [31:0] e);
    reg [31:0] v;
    begin
      wreg(a, d);
      rreg(a, v);
      chk("param", v, e);
    end
  endtask
  task t_noop;
    integer n;
    begin
      wreg(`GP_REG_CMD, 32'h4);
      count_nv(30, n);
      chk("noop writes", n, 0);
      $display("t_noop done");
    end
  endtask
  task t_ranges;
    reg [31:0] s;
    begin
      chk("gate", vocGate, 32'hb4);
      chk("std", vocStdDev, 32'h32);
      chk("gain", vocGain, 32'he6);
      tryset(8'h0c, 32'hbb8, 32'hbb8);
      tryset(8'h0c, 32'hbb9, 32'hbb8);
      tryset(8'h10, 32'h9, 32'h32);
      tryset(8'h10, 32'h1388, 32'h1388);
      tryset(8'h14, 32'h0, 32'he6);
      tryset(8'h14, 32'h3e8, 32'h3e8);
      rreg(`GP_REG_STATUS, s);
      chk("reject", s[4], 1'b1);
      wreg(`GP_REG_CMD, 32'h10);
      rreg(`GP_REG_STATUS, s);
      chk("reject clear", s[4], 1'b0);
      $display("t_ranges done");
    end
  endtask
  task t_measure;
    integer n;
    begin
      wreg(8'h0c, 32'h2);
      wreg(8'h18, 32'h0);
      wreg(`GP_REG_CMD, 32'h1);
      indexHigh <= 2'b11;
      repeat (5) @(posedge clk);
      #1;
      chk("voc freeze", estimatorFreeze, 2'b01);
      n = 0;
      while (estimatorFreeze[0] === 1'b1 && n < 1400) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk("gate time", n >= 590 && n <= 1215, 1);
      indexHigh <= 2'b00;
      count_nv(0, n);
      n = 0;
      repeat (100) begin
        @(posedge clk);
        #1;
        if (measureTick === 1'b1)
          n = n + 1;
      end
      chk("ticks", n, 10);
      // scaled stand-in for the hours of measuring before states are worth keeping
      rreg(8'h24, keptState0);
      rreg(8'h28, keptState1);
      chk("live state0", keptState0, 32'h1234abcd);
      chk("live state1", keptState1, 32'h0badf00d);
      wreg(`GP_REG_CMD, 32'h4);
      count_nv(40, n);
      chk("commit writes", n, 7);
      chk("stored gate", nv.mem[1], 32'h2);
      wreg(8'h08, 32'h5);
      #1;
      chk("busy offset", tempOffset, 32'h0);
      wreg(`GP_REG_CMD, 32'h2);
      wreg(8'h08, 32'h7);
      #1;
      chk("idle offset", tempOffset, 32'h7);
      wreg(`GP_REG_CMD, 32'h8);
      settle;
      chk("lost offset", tempOffset, 32'h0);
      chk("kept gate", vocGate, 32'h2);
      chk("idle", measuring, 1'b0);
      chk("kept nox gate", noxGate, 32'h0);
      $display("t_measure done");
    end
  endtask
  task t_states;
    integer    n;
    begin
      // the firmware has moved on; only the kept copy may come back
      @(posedge clk);
      vocStateIn0 <= 32'ha5a5a5a5;
      vocStateIn1 <= 32'h3c3c0ff0;
      wreg(8'h24, keptState0);
      wreg(8'h28, keptState1);
      wreg(`GP_REG_CMD, 32'h1);
      #1;
      n = 0;
      while (vocStateLoad !== 1'b1 && n < 10) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk("load pulse", n, 0);
      chk("restore0", vocStateOut0, 32'h1234abcd);
      chk("restore1", vocStateOut1, 32'h0badf00d);
      @(posedge clk);
      #1;
      chk("skip learn", startupPhase, 1'b0);
      wreg(`GP_REG_CMD, 32'h2);
      wreg(`GP_REG_CMD, 32'h1);
      #1;
      chk("no reload", vocStateLoad, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      chk("learn", startupPhase, 1'b1);
      $display("t_states done");
    end
  endtask
  task t_factory;
    integer n;
    begin
      wreg(`GP_REG_CMD, 32'h2);
      wreg(8'h08, 32'h0);
      wreg(8'h0c, 32'hb4);
      wreg(8'h10, 32'h32);
      wreg(8'h14, 32'he6);
      wreg(8'h18, 32'hb4);
      wreg(8'h1c, 32'h32);
      wreg(8'h20, 32'he6);
      wreg(`GP_REG_CMD, 32'h4);
      count_nv(40, n);
      chk("default writes", n, 7);
      wreg(`GP_REG_CMD, 32'h8);
      settle;
      chk("default gate", vocGate, 32'hb4);
      chk("default std", vocStdDev, 32'h32);
      chk("default gain", vocGain, 32'he6);
      chk("default nox gate", noxGate, 32'hb4);
      chk("default nox std", noxStdDev, 32'h32);
      chk("default nox gain", noxGain, 32'he6);
      $display("t_factory done");
    end
  endtask
  task results;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // cut a hang short well past the expected run of under two thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      results;
    end
  end
  initial begin
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    indexHigh = 2'b00;
    vocStateIn0 = 32'h1234abcd;
    vocStateIn1 = 32'h0badf00d;
    err_count = 0;
    n_compared = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    settle;
    t_noop;
    t_ranges;
    t_measure;
    t_states;
    t_factory;
    results;
  end
endmodule
bind gas_index_param_store_ctrl gas_ctrl_props #(.SEC_CYCLES(SEC_CYCLES)) props (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .nvRdEn(nvRdEn),
  .nvWrEn(nvWrEn), .nvAddr(nvAddr), .indexHigh(indexHigh), .measuring(measuring),
  .measureTick(measureTick), .startupPhase(startupPhase), .estimatorFreeze(estimatorFreeze),
  .vocStateLoad(vocStateLoad), .tempOffset(tempOffset), .vocGate(vocGate),
  .vocStdDev(vocStdDev), .vocGain(vocGain), .noxGate(noxGate));
